//--- design/fsrr_pkg.sv
// Constants for the flash status register read block.
// Assumes one 200 MHz reference clock samples every serial pin.
package fsrr_pkg;
  // Opcodes
  localparam logic [7:0] FSRR_OP_READ_STATUS = 8'h05;
  localparam logic [7:0] FSRR_OP_WRITE_BYTE_ONE = 8'h01;
  localparam logic [7:0] FSRR_OP_WRITE_BYTE_TWO = 8'h31;
  // Byte one field positions
  localparam int FSRR_B1_LOCK = 7;
  localparam int FSRR_B1_RSV = 6;
  localparam int FSRR_B1_ERR = 5;
  localparam int FSRR_B1_PROT_PIN = 4;
  localparam int FSRR_B1_COVER_HI = 3;
  localparam int FSRR_B1_COVER_LO = 2;
  localparam int FSRR_B1_WR_EN = 1;
  localparam int FSRR_BUSY = 0;
  // Byte two field positions
  localparam int FSRR_B2_RST_EN = 4;
  localparam int FSRR_B2_LOCKDN_EN = 3;
  localparam int FSRR_B2_PROG_SUSP = 2;
  localparam int FSRR_B2_ERASE_SUSP = 1;
  // Reset values of the writable bits
  localparam logic FSRR_LOCK_RST = 1'b0;
  localparam logic FSRR_RST_EN_RST = 1'b0;
  localparam logic FSRR_LOCKDN_EN_RST = 1'b0;
  // Bit counter
  localparam logic [2:0] FSRR_LAST_BIT = 3'h7;
  localparam logic [2:0] FSRR_FIRST_BIT = 3'h0;
  typedef enum logic [2:0] {
    FSRR_OPCODE,
    FSRR_READ,
    FSRR_WRITE_ONE,
    FSRR_WRITE_TWO,
    FSRR_IGNORE
  } fsrr_state_t;
endpackage

//--- design/fsrr_top.sv
// Serial status register of a flash device with its read and write commands.
// Assumes a mode 0 or mode 3 serial host; serial pins are asynchronous to I_REF_CLK.
// Behaviour
// - After chip select and read-status opcode, status bits go out every clock.
// - After byte two, output returns to byte one while select and clock continue.
// - Each repeated byte reflects current internal state, not a start snapshot.
// - Bit 0 of both bytes shows busy, sampled afresh for each byte.
// - Read-status is accepted at any time, even during program or erase.
// - Releasing select anywhere ends the read and floats the serial output.
// - Byte one bit 7 is writable protection lock flag, reset 0.
// - Byte one bit 5 is read-only program or erase error flag.
// - Byte one bit 4 reads 0 while write-protect pin asserted, else 1.
// - Byte one bits 3:2 report software protection coverage, default all.
// - Byte one bit 1 shows write enable latch, read-only.
// - Byte two bit 4 is writable reset-command enable, reset 0.
// - Byte two bit 3 is writable lockdown-command enable, reset 0.
// - Byte two bit 2 reads 1 while a sector is program suspended.
// - Byte two bit 1 reads 1 while a sector is erase suspended.
// - Byte one write changes only bit 7.
// - Byte two write changes only bits 4 and 3.
// - With write-protect pin asserted the lock flag may only go 0 to 1.
// - Reset-command enable holds until rewritten or power cycled.
`timescale 1ns/1ps
module fsrr_top
  import fsrr_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Serial pins
  input wire logic I_CS_N,
  input wire logic I_SCK,
  input wire logic I_SI,
  input wire logic I_WP_N,
  output logic O_SO,
  output logic O_SO_OE,
  // Internal device state
  input wire logic I_BUSY_FLAG,
  input wire logic I_PROGRAM_ERASE_ERROR,
  input wire logic [1:0] I_SOFTWARE_PROTECT_STATE,
  input wire logic I_WRITE_ENABLE_LATCH,
  input wire logic I_PROGRAM_SUSPEND_FLAG,
  input wire logic I_ERASE_SUSPEND_FLAG,
  // Writable status bits and write completion
  output logic O_PROTECTION_LOCK_FLAG,
  output logic O_RESET_CMD_ENABLE,
  output logic O_LOCKDOWN_CMD_ENABLE,
  output logic O_STATUS_WRITE_DONE
);
  import fsrr_pkg::*;

  logic rst_meta_r;
  logic rst_n_r;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic sck_prev_r;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  fsrr_state_t state_r;
  logic [2:0] in_cnt_r;
  logic [7:0] in_shift_r;
  logic [7:0] in_byte;
  logic [2:0] out_cnt_r;
  logic [7:0] out_shift_r;
  logic byte_sel_r;
  logic [7:0] byte_one;
  logic [7:0] byte_two;
  logic [7:0] live_byte;
  logic lock_r;
  logic rst_en_r;
  logic lockdn_en_r;
  logic so_r;
  logic so_oe_r;
  logic done_r;

  // Reset release
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pin synchronisers: {wp_n, si, sck, cs_n}
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 4'hF;
      pin_sync_r <= 4'hF;
      sck_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= {I_WP_N, I_SI, I_SCK, I_CS_N};
      pin_sync_r <= pin_meta_r;
      sck_prev_r <= pin_sync_r[1];
    end
  end

  assign cs_n_s = pin_sync_r[0];
  assign sck_s = pin_sync_r[1];
  assign si_s = pin_sync_r[2];
  assign wp_n_s = pin_sync_r[3];
  assign selected = !cs_n_s;
  assign sck_rise = selected && sck_s && !sck_prev_r;
  assign sck_fall = selected && !sck_s && sck_prev_r;
  assign in_byte = {in_shift_r[6:0], si_s};

  // Live status bytes, rebuilt every cycle
  always_comb begin
    byte_one = 8'h00;
    byte_one[FSRR_B1_LOCK] = lock_r;
    byte_one[FSRR_B1_ERR] = I_PROGRAM_ERASE_ERROR;
    byte_one[FSRR_B1_PROT_PIN] = wp_n_s;
    byte_one[FSRR_B1_COVER_HI:FSRR_B1_COVER_LO] = I_SOFTWARE_PROTECT_STATE;
    byte_one[FSRR_B1_WR_EN] = I_WRITE_ENABLE_LATCH;
    byte_one[FSRR_BUSY] = I_BUSY_FLAG;
    byte_two = 8'h00;
    byte_two[FSRR_B2_RST_EN] = rst_en_r;
    byte_two[FSRR_B2_LOCKDN_EN] = lockdn_en_r;
    byte_two[FSRR_B2_PROG_SUSP] = I_PROGRAM_SUSPEND_FLAG;
    byte_two[FSRR_B2_ERASE_SUSP] = I_ERASE_SUSPEND_FLAG;
    byte_two[FSRR_BUSY] = I_BUSY_FLAG;
    live_byte = byte_sel_r ? byte_two : byte_one;
  end

  // Command decode; read-status needs no busy check
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= FSRR_OPCODE;
      in_cnt_r <= FSRR_FIRST_BIT;
      in_shift_r <= 8'h00;
    end else if (!selected) begin
      state_r <= FSRR_OPCODE;
      in_cnt_r <= FSRR_FIRST_BIT;
    end else if (sck_rise) begin
      in_shift_r <= in_byte;
      in_cnt_r <= in_cnt_r + 3'h1;
      if (in_cnt_r == FSRR_LAST_BIT) begin
        case (state_r)
          FSRR_OPCODE: begin
            if (in_byte == FSRR_OP_READ_STATUS) begin
              state_r <= FSRR_READ;
            end else if (in_byte == FSRR_OP_WRITE_BYTE_ONE && I_WRITE_ENABLE_LATCH) begin
              state_r <= FSRR_WRITE_ONE;
            end else if (in_byte == FSRR_OP_WRITE_BYTE_TWO && I_WRITE_ENABLE_LATCH) begin
              state_r <= FSRR_WRITE_TWO;
            end else begin
              state_r <= FSRR_IGNORE;
            end
          end
          FSRR_READ: state_r <= FSRR_READ;
          FSRR_WRITE_ONE: state_r <= FSRR_IGNORE;
          FSRR_WRITE_TWO: state_r <= FSRR_IGNORE;
          FSRR_IGNORE: state_r <= FSRR_IGNORE;
          default: state_r <= FSRR_IGNORE;
        endcase
      end
    end
  end

  // Writable status bits, changed only by a complete data byte
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_r <= FSRR_LOCK_RST;
      rst_en_r <= FSRR_RST_EN_RST;
      lockdn_en_r <= FSRR_LOCKDN_EN_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (selected && sck_rise && in_cnt_r == FSRR_LAST_BIT) begin
        if (state_r == FSRR_WRITE_ONE) begin
          done_r <= 1'b1;
          if (wp_n_s || in_byte[FSRR_B1_LOCK]) begin
            lock_r <= in_byte[FSRR_B1_LOCK];
          end
        end else if (state_r == FSRR_WRITE_TWO) begin
          done_r <= 1'b1;
          rst_en_r <= in_byte[FSRR_B2_RST_EN];
          lockdn_en_r <= in_byte[FSRR_B2_LOCKDN_EN];
        end
      end
    end
  end

  // Status shifter: new byte loaded on the first falling edge of each byte
  always_ff @(posedge I_REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_cnt_r <= FSRR_FIRST_BIT;
      out_shift_r <= 8'h00;
      byte_sel_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (!selected || state_r != FSRR_READ) begin
      out_cnt_r <= FSRR_FIRST_BIT;
      byte_sel_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (sck_fall) begin
      so_oe_r <= 1'b1;
      out_cnt_r <= out_cnt_r + 3'h1;
      if (out_cnt_r == FSRR_FIRST_BIT) begin
        so_r <= live_byte[7];
        out_shift_r <= {live_byte[6:0], 1'b0};
      end else begin
        so_r <= out_shift_r[7];
        out_shift_r <= {out_shift_r[6:0], 1'b0};
      end
      if (out_cnt_r == FSRR_LAST_BIT) begin
        byte_sel_r <= !byte_sel_r;
      end
    end
  end

  assign O_SO = so_r;
  assign O_SO_OE = so_oe_r;
  assign O_PROTECTION_LOCK_FLAG = lock_r;
  assign O_RESET_CMD_ENABLE = rst_en_r;
  assign O_LOCKDOWN_CMD_ENABLE = lockdn_en_r;
  assign O_STATUS_WRITE_DONE = done_r;
endmodule // fsrr_top

//--- test/fsrr_host.sv
// Host serial controller model driving the status register block.
// Assumes mode 0 framing with a 125 ns link clock.
`timescale 1ns/1ps
module fsrr_host (
  // Serial pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // Opcode, then n bits; SO taken at each rise after the opcode
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n,
                       output logic [31:0] rd);
    logic [15:0] sh;
    sh = {op, d};
    o_cs_n = 1'b0;
    #40;
    for (int i = 0; i < 8 + n; i++) begin
      o_si = sh[15];
      sh = {sh[14:0], ~sh[15]};
      #62.5;
      o_sck = 1'b1;
      if (i >= 8) rd = {rd[30:0], i_so_oe ? i_so : 1'bx};
      #62.5;
      o_sck = 1'b0;
    end
    #62.5;
    o_cs_n = 1'b1;
    // Released data line shows no stale value
    o_si = ~o_si;
    #100;
  endtask
endmodule // fsrr_host

//--- test/fsrr_checker.sv
// Checker of the status register block port timing.
// Assumes it is bound to fsrr_top.
`timescale 1ns/1ps
module fsrr_checker (
  input wire logic I_REF_CLK, I_RSTN, I_CS_N, I_SCK, I_WP_N, O_SO, O_SO_OE,
  input wire logic O_PROTECTION_LOCK_FLAG, O_RESET_CMD_ENABLE, O_LOCKDOWN_CMD_ENABLE,
  input wire logic O_STATUS_WRITE_DONE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  oe_idle_off_a: assert property (I_CS_N [*6] |-> !O_SO_OE)
    else $error("SO driven while deselected");
  oe_needs_cs_a: assert property ($rose(O_SO_OE) |-> !I_CS_N)
    else $error("SO enabled without select");
  so_after_fall_a:
    assert property ($changed(O_SO) && O_SO_OE && $past(O_SO_OE) |-> !$past(I_SCK, 2))
    else $error("SO moved outside a clock fall");
  lock_keep_wp_a:
    assert property (!I_WP_N [*8] |-> !$fell(O_PROTECTION_LOCK_FLAG))
    else $error("lock cleared while protect pin asserted");
  done_single_a: assert property (O_STATUS_WRITE_DONE |=> !O_STATUS_WRITE_DONE)
    else $error("write done longer than one cycle");
  lock_by_write_a:
    assert property ($changed(O_PROTECTION_LOCK_FLAG)
      |-> O_STATUS_WRITE_DONE || $past(O_STATUS_WRITE_DONE))
    else $error("lock changed without a write");
  reset_en_write_a:
    assert property ($changed(O_RESET_CMD_ENABLE)
      |-> O_STATUS_WRITE_DONE || $past(O_STATUS_WRITE_DONE))
    else $error("reset enable changed without a write");
  lockdown_en_write_a:
    assert property ($changed(O_LOCKDOWN_CMD_ENABLE)
      |-> O_STATUS_WRITE_DONE || $past(O_STATUS_WRITE_DONE))
    else $error("lockdown enable changed without a write");
endmodule // fsrr_checker
bind fsrr_top fsrr_checker fsrr_checker_i (.*);

//--- test/fsrr_top_tb.sv
// Self-checking bench of the status register block.
// Assumes fsrr_host drives the serial pins.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module fsrr_top_tb;
  import fsrr_pkg::*;
  logic clk = 0, rstn = 0, wp_n = 1, busy = 1, err = 1, wr_en = 0, prog_susp = 1;
  logic erase_susp = 0;
  logic [1:0] prot_cover = 2'h1;
  logic cs_n, sck, si, so, oe, lock, rst_en, lockdn_en, done;
  logic [31:0] rd;
  int miscompares = 0, samples_checked = 0, done_cnt = 0;
  initial forever #2.5 clk = ~clk;
  // Counts accepted status writes
  always @(posedge clk) if (done === 1'b1) done_cnt++;
  fsrr_host fsrr_host_i (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(oe));
  fsrr_top fsrr_top_i (.I_REF_CLK(clk), .I_RSTN(rstn), .I_CS_N(cs_n), .I_SCK(sck),
    .I_SI(si), .I_WP_N(wp_n), .O_SO(so), .O_SO_OE(oe), .I_BUSY_FLAG(busy),
    .I_PROGRAM_ERASE_ERROR(err), .I_SOFTWARE_PROTECT_STATE(prot_cover),
    .I_WRITE_ENABLE_LATCH(wr_en), .I_PROGRAM_SUSPEND_FLAG(prog_susp),
    .I_ERASE_SUSPEND_FLAG(erase_susp),
    .O_PROTECTION_LOCK_FLAG(lock), .O_RESET_CMD_ENABLE(rst_en),
    .O_LOCKDOWN_CMD_ENABLE(lockdn_en), .O_STATUS_WRITE_DONE(done));
  task automatic end_of_test();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Write frame with the write enable latch set
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    @(posedge clk) #1 wr_en = 1;
    fsrr_host_i.frame(op, d, 8, rd);
    @(posedge clk) #1 wr_en = 0;
  endtask
  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    repeat (10) @(posedge clk);
    `CHK({lock, rst_en, lockdn_en, oe}, 4'h0)
    fork
      fsrr_host_i.frame(FSRR_OP_READ_STATUS, 8'h00, 32, rd);
      begin
        #2500;
        @(posedge clk) #1 busy = 0;
        erase_susp = 1;
      end
    join
    `CHK(rd, 32'h35053406)
    fsrr_host_i.frame(FSRR_OP_WRITE_BYTE_ONE, 8'hFF, 8, rd);
    `CHK(lock, 1'b0)
    wr(FSRR_OP_WRITE_BYTE_ONE, 8'hFF);
    `CHK(lock, 1'b1)
    @(posedge clk) #1 wp_n = 0;
    wr(FSRR_OP_WRITE_BYTE_ONE, 8'h00);
    `CHK(lock, 1'b1)
    fsrr_host_i.frame(FSRR_OP_READ_STATUS, 8'h00, 16, rd);
    `CHK(rd[15:0], 16'hA406)
    @(posedge clk) #1 wp_n = 1;
    wr(FSRR_OP_WRITE_BYTE_ONE, 8'h00);
    `CHK(lock, 1'b0)
    wr(FSRR_OP_WRITE_BYTE_TWO, 8'hFF);
    `CHK({rst_en, lockdn_en}, 2'h3)
    fsrr_host_i.frame(FSRR_OP_READ_STATUS, 8'h00, 16, rd);
    `CHK(rd[15:0], 16'h341E)
    `CHK({rst_en, lockdn_en}, 2'h3)
    wr(FSRR_OP_WRITE_BYTE_TWO, 8'h00);
    `CHK({rst_en, lockdn_en}, 2'h0)
    fsrr_host_i.frame(FSRR_OP_READ_STATUS, 8'h00, 5, rd);
    `CHK(oe, 1'b0)
    `CHK(done_cnt, 5)
    end_of_test();
  end
endmodule // fsrr_top_tb
